// file: design/xsd_pkg.sv
package xsd_pkg;

  // ------------------------------------------------------------
  // register map (byte offsets on the 32-bit bus)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_INSTR   = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_ACC     = 8'h0C;
  localparam logic [7:0] OFS_BANK    = 8'h10;
  localparam logic [7:0] OFS_PTR0    = 8'h14;
  localparam logic [7:0] OFS_PTR1    = 8'h18;
  localparam logic [7:0] OFS_PTR2    = 8'h1C;
  localparam logic [7:0] OFS_PC      = 8'h20;
  localparam logic [7:0] OFS_TOS     = 8'h24;
  localparam logic [7:0] OFS_MADDR   = 8'h28;
  localparam logic [7:0] OFS_MDATA   = 8'h2C;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int         CTRL_EXT_BIT = 0;
  localparam logic       CTRL_EXT_RST = 1'b1;
  localparam int         STAT_BUSY    = 0;
  localparam int         STAT_WAIT2   = 1;
  localparam int         STAT_NEG     = 2;
  localparam int         STAT_ZERO    = 3;
  localparam int         STAT_ILL     = 4;

  // ------------------------------------------------------------
  // addressing and opcode constants
  // ------------------------------------------------------------
  localparam logic [7:0] LIT_OFS_MAX  = 8'h5F;
  localparam logic [3:0] ACC_HI_BANK  = 4'hF;
  localparam logic [3:0] ACC_LO_BANK  = 4'h0;
  localparam logic [5:0] OPC_XOR      = 6'h06;
  localparam logic [7:0] OPC_ADDP     = 8'hE8;
  localparam logic [7:0] OPC_SUBP     = 8'hE9;
  localparam logic [7:0] OPC_PUSH_LITERAL    = 8'hEA;
  localparam logic [7:0] OPC_MOVS     = 8'hEB;
  localparam logic [15:0] OPC_CALL_VIA_ACCUMULATOR   = 16'h0014;
  localparam logic [3:0] OPC_WORD2    = 4'hF;
  localparam logic [1:0] FRAME_SEL    = 2'h3;

  // ------------------------------------------------------------
  // timing: one instruction cycle is four quarter phases
  // ------------------------------------------------------------
  localparam logic [1:0] Q_LAST       = 2'h3;
  localparam logic [1:0] CYC_ONE      = 2'h1;
  localparam logic [1:0] CYC_TWO      = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT2 = 2'b01,
    ST_EXEC  = 2'b10
  } xsd_state_t;

  typedef enum logic [3:0] {
    OP_ILL    = 4'h0,
    OP_XOR    = 4'h1,
    OP_ADDP   = 4'h2,
    OP_SUBP   = 4'h3,
    OP_ADDRET = 4'h4,
    OP_SUBRET = 4'h5,
    OP_CALL_VIA_ACCUMULATOR  = 4'h6,
    OP_MOVE_FRAME_TO_FILE  = 4'h7,
    OP_MOVE_FRAME_TO_FRAME  = 4'h8,
    OP_PUSH_LITERAL  = 4'h9
  } xsd_op_t;

  typedef struct packed {
    xsd_op_t    op;
    logic       two_word;
    logic [1:0] cycles;
  } xsd_dec_t;

  typedef struct packed {
    logic        en;
    logic [11:0] addr;
    logic [7:0]  data;
  } xsd_memwr_t;

endpackage : xsd_pkg

// file: design/xsd_decode.sv
`timescale 1ns/1ps
module xsd_decode (
  // instruction word
  input  wire logic [15:0]      word,
  input  wire logic             ext_en,
  // decoded result
  output xsd_pkg::xsd_dec_t     dec
);
  import xsd_pkg::*;

  always_comb begin
    dec = '{op: OP_ILL, two_word: 1'b0, cycles: CYC_ONE};
    if (word[15:10] == OPC_XOR) begin
      dec.op = OP_XOR;
    end else if (ext_en) begin
      // extension opcodes decode only while enabled
      case (word[15:8])
        OPC_ADDP: begin
          dec.op     = (word[7:6] == FRAME_SEL) ? OP_ADDRET : OP_ADDP;
          dec.cycles = (word[7:6] == FRAME_SEL) ? CYC_TWO : CYC_ONE;
        end
        OPC_SUBP: begin
          dec.op     = (word[7:6] == FRAME_SEL) ? OP_SUBRET : OP_SUBP;
          dec.cycles = (word[7:6] == FRAME_SEL) ? CYC_TWO : CYC_ONE;
        end
        OPC_PUSH_LITERAL: dec.op = OP_PUSH_LITERAL;
        OPC_MOVS: begin
          dec.op       = word[7] ? OP_MOVE_FRAME_TO_FRAME : OP_MOVE_FRAME_TO_FILE;
          dec.two_word = 1'b1;
          dec.cycles   = CYC_TWO;
        end
        default: begin
          if (word == OPC_CALL_VIA_ACCUMULATOR) begin
            dec.op     = OP_CALL_VIA_ACCUMULATOR;
            dec.cycles = CYC_TWO;
          end
        end
      endcase
    end
  end

endmodule : xsd_decode

// file: design/xsd_dmem.sv
`timescale 1ns/1ps
module xsd_dmem (
  // clock
  input  wire logic               pclk,
  // ports
  input  xsd_pkg::xsd_memwr_t     wr,
  input  wire logic [11:0]        raddr,
  output logic [7:0]              rdata
);
  import xsd_pkg::*;

  // no reset: file contents are undefined after power-up
  logic [7:0] mem [4096];

  always_ff @(posedge pclk) begin
    if (wr.en) begin
      mem[wr.addr] <= wr.data;
    end
  end

  // read is combinational so read-modify-write fits one edge
  assign rdata = mem[raddr];

endmodule : xsd_dmem

// file: design/xsd_core.sv
`timescale 1ns/1ps
module xsd_core (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  import xsd_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  xsd_state_t        state_reg,  state_next;
  logic [1:0]        q_reg,      q_next;
  logic [1:0]        cyc_reg,    cyc_next;
  logic [15:0]       ir_reg,     ir_next;
  logic [15:0]       w2_reg,     w2_next;
  logic [7:0]        acc_reg,    acc_next;
  logic [3:0]        bank_reg,   bank_next;
  logic [2:0][11:0]  ptr_reg,    ptr_next;
  logic [15:0]       pc_reg,     pc_next;
  logic [15:0]       tos_reg,    tos_next;
  logic [11:0]       maddr_reg,  maddr_next;
  logic              ext_reg,    ext_next;
  logic              neg_reg,    neg_next;
  logic              zero_reg,   zero_next;
  logic              ill_reg,    ill_next;
  logic [31:0]       prdata_reg, prdata_next;

  xsd_dec_t          dec;
  xsd_memwr_t        mem_wr;
  logic [11:0]       mem_raddr;
  logic [7:0]        mem_rdata;
  logic [7:0]        xor_res;
  logic [11:0]       file_ea;
  logic [11:0]       src_ea;
  logic [11:0]       lit6;
  logic [1:0]        sel;
  logic [31:0]       rd_mux;
  logic              setup;
  logic              access;
  logic              addr_hit;
  logic              acc_wr;
  logic              issue;
  logic              fire;

  // ------------------------------------------------------------
  // address helpers
  // ------------------------------------------------------------
  function automatic logic [11:0] frame_ofs(input logic [11:0] frame,
                                            input logic [6:0]  ofs);
    frame_ofs = frame + {5'h0, ofs};
  endfunction : frame_ofs

  function automatic logic [11:0] file_addr(input logic [7:0]  f,
                                            input logic        a,
                                            input logic        ext,
                                            input logic [3:0]  bank,
                                            input logic [11:0] frame);
    if (a) begin
      file_addr = {bank, f};
    end else if (ext && f <= LIT_OFS_MAX) begin
      file_addr = frame + {4'h0, f};
    end else if (f > LIT_OFS_MAX) begin
      file_addr = {ACC_HI_BANK, f};
    end else begin
      file_addr = {ACC_LO_BANK, f};
    end
  endfunction : file_addr

  // ------------------------------------------------------------
  // decode and data memory
  // ------------------------------------------------------------
  // first word is decoded straight off the bus while idle
  xsd_decode xsd_decode_i (
    .word   ((state_reg == ST_IDLE) ? pwdata[15:0] : ir_reg),
    .ext_en (ext_reg),
    .dec    (dec)
  );

  xsd_dmem xsd_dmem_i (
    .pclk  (pclk),
    .wr    (mem_wr),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  assign file_ea = file_addr(ir_reg[7:0], ir_reg[8], ext_reg, bank_reg,
                             ptr_reg[2]);
  assign src_ea  = frame_ofs(ptr_reg[2], ir_reg[6:0]);
  assign lit6    = {6'h0, ir_reg[5:0]};
  assign sel     = ir_reg[7:6];
  assign xor_res = acc_reg ^ mem_rdata;

  always_comb begin
    mem_raddr = maddr_reg;
    if (state_reg == ST_EXEC) begin
      if (dec.op == OP_XOR) begin
        mem_raddr = file_ea;
      end else if (dec.op == OP_MOVE_FRAME_TO_FILE || dec.op == OP_MOVE_FRAME_TO_FRAME) begin
        mem_raddr = src_ea;
      end
    end
  end

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  // writes stall while an instruction runs, so bus and core never
  // update the same register in one edge
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign pready   = !(pwrite && state_reg == ST_EXEC);
  assign addr_hit = (paddr[1:0] == 2'h0) && (paddr <= OFS_MDATA);
  assign pslverr  = access && !addr_hit;
  assign acc_wr   = access && pwrite && pready && addr_hit;
  assign issue    = acc_wr && (paddr == OFS_INSTR);
  assign prdata   = prdata_reg;
  assign fire     = (state_reg == ST_EXEC) && (q_reg == Q_LAST)
                    && (cyc_reg == dec.cycles);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL:   rd_mux[CTRL_EXT_BIT] = ext_reg;
      OFS_INSTR:  rd_mux = {16'h0000, ir_reg};
      OFS_STATUS: begin
        rd_mux[STAT_BUSY]  = (state_reg == ST_EXEC);
        rd_mux[STAT_WAIT2] = (state_reg == ST_WAIT2);
        rd_mux[STAT_NEG]   = neg_reg;
        rd_mux[STAT_ZERO]  = zero_reg;
        rd_mux[STAT_ILL]   = ill_reg;
      end
      OFS_ACC:    rd_mux = {24'h00_0000, acc_reg};
      OFS_BANK:   rd_mux = {28'h000_0000, bank_reg};
      OFS_PTR0:   rd_mux = {20'h0_0000, ptr_reg[0]};
      OFS_PTR1:   rd_mux = {20'h0_0000, ptr_reg[1]};
      OFS_PTR2:   rd_mux = {20'h0_0000, ptr_reg[2]};
      OFS_PC:     rd_mux = {16'h0000, pc_reg};
      OFS_TOS:    rd_mux = {16'h0000, tos_reg};
      OFS_MADDR:  rd_mux = {20'h0_0000, maddr_reg};
      OFS_MDATA:  rd_mux = {24'h00_0000, mem_rdata};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    q_next      = q_reg;
    cyc_next    = cyc_reg;
    ir_next     = ir_reg;
    w2_next     = w2_reg;
    acc_next    = acc_reg;
    bank_next   = bank_reg;
    ptr_next    = ptr_reg;
    pc_next     = pc_reg;
    tos_next    = tos_reg;
    maddr_next  = maddr_reg;
    ext_next    = ext_reg;
    neg_next    = neg_reg;
    zero_next   = zero_reg;
    ill_next    = ill_reg;
    prdata_next = setup ? rd_mux : prdata_reg;
    mem_wr      = '0;

    if (acc_wr) begin
      case (paddr)
        OFS_CTRL:   ext_next = pwdata[CTRL_EXT_BIT];
        OFS_STATUS: if (pwdata[STAT_ILL]) ill_next = 1'b0;
        OFS_ACC:    acc_next = pwdata[7:0];
        OFS_BANK:   bank_next = pwdata[3:0];
        OFS_PTR0:   ptr_next[0] = pwdata[11:0];
        OFS_PTR1:   ptr_next[1] = pwdata[11:0];
        OFS_PTR2:   ptr_next[2] = pwdata[11:0];
        OFS_PC:     pc_next = pwdata[15:0];
        OFS_TOS:    tos_next = pwdata[15:0];
        OFS_MADDR:  maddr_next = pwdata[11:0];
        OFS_MDATA:  mem_wr = '{en: 1'b1, addr: maddr_reg,
                               data: pwdata[7:0]};
        default: ;
      endcase
    end

    // issue comes after the clear, so a new fault wins over it
    if (issue) begin
      if (state_reg == ST_WAIT2) begin
        if (pwdata[15:12] == OPC_WORD2) begin
          w2_next    = pwdata[15:0];
          state_next = ST_EXEC;
          q_next     = 2'h0;
          cyc_next   = dec.cycles;
        end else begin
          ill_next   = 1'b1;
          state_next = ST_IDLE;
        end
      end else begin
        ir_next = pwdata[15:0];
        if (dec.op == OP_ILL) begin
          ill_next = 1'b1;
        end else if (dec.two_word) begin
          state_next = ST_WAIT2;
        end else begin
          state_next = ST_EXEC;
          q_next     = 2'h0;
          cyc_next   = dec.cycles;
        end
      end
    end

    // quarter-phase sequencer; later cycles are idle phases
    if (state_reg == ST_EXEC) begin
      q_next = q_reg + 2'h1;
      if (q_reg == Q_LAST) begin
        cyc_next = cyc_reg - 2'h1;
        if (cyc_reg == CYC_ONE) begin
          state_next = ST_IDLE;
        end
      end
    end

    // all results land in the fourth phase of the first cycle
    if (fire) begin
      case (dec.op)
        OP_XOR: begin
          if (ir_reg[9]) begin
            mem_wr = '{en: 1'b1, addr: file_ea, data: xor_res};
          end else begin
            acc_next = xor_res;
          end
          neg_next  = xor_res[7];
          zero_next = (xor_res == 8'h00);
        end
        OP_ADDP: ptr_next[sel] = ptr_reg[sel] + lit6;
        OP_SUBP: ptr_next[sel] = ptr_reg[sel] - lit6;
        OP_ADDRET: begin
          ptr_next[2] = ptr_reg[2] + lit6;
          pc_next     = tos_reg;
        end
        OP_SUBRET: begin
          ptr_next[2] = ptr_reg[2] - lit6;
          pc_next     = tos_reg;
        end
        OP_CALL_VIA_ACCUMULATOR: begin
          tos_next = pc_reg;
          pc_next  = {pc_reg[15:8], acc_reg};
        end
        OP_MOVE_FRAME_TO_FILE: mem_wr = '{en: 1'b1, addr: w2_reg[11:0],
                             data: mem_rdata};
        OP_MOVE_FRAME_TO_FRAME: mem_wr = '{en: 1'b1,
                             addr: frame_ofs(ptr_reg[2], w2_reg[6:0]),
                             data: mem_rdata};
        OP_PUSH_LITERAL: begin
          mem_wr = '{en: 1'b1, addr: ptr_reg[2], data: ir_reg[7:0]};
          ptr_next[2] = ptr_reg[2] - 12'h001;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= ST_IDLE;
      q_reg      <= 2'h0;
      cyc_reg    <= 2'h0;
      ir_reg     <= 16'h0000;
      w2_reg     <= 16'h0000;
      acc_reg    <= 8'h00;
      bank_reg   <= 4'h0;
      ptr_reg    <= '0;
      pc_reg     <= 16'h0000;
      tos_reg    <= 16'h0000;
      maddr_reg  <= 12'h000;
      ext_reg    <= CTRL_EXT_RST;
      neg_reg    <= 1'b0;
      zero_reg   <= 1'b0;
      ill_reg    <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      state_reg  <= state_next;
      q_reg      <= q_next;
      cyc_reg    <= cyc_next;
      ir_reg     <= ir_next;
      w2_reg     <= w2_next;
      acc_reg    <= acc_next;
      bank_reg   <= bank_next;
      ptr_reg    <= ptr_next;
      pc_reg     <= pc_next;
      tos_reg    <= tos_next;
      maddr_reg  <= maddr_next;
      ext_reg    <= ext_next;
      neg_reg    <= neg_next;
      zero_reg   <= zero_next;
      ill_reg    <= ill_next;
      prdata_reg <= prdata_next;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  xor_acc_dest_a: assert property (
    fire && dec.op == OP_XOR && !ir_reg[9]
    |=> acc_reg == $past(xor_res)
  ) else $error("xor result missing from accumulator");

  xor_file_dest_a: assert property (
    fire && dec.op == OP_XOR && ir_reg[9]
    |-> mem_wr.en && mem_wr.addr == file_ea
        && mem_wr.data == (acc_reg ^ mem_rdata)
  ) else $error("xor result not written to file");

  bank_select_a: assert property (
    state_reg == ST_EXEC && dec.op == OP_XOR && ir_reg[8]
    |-> mem_raddr == {bank_reg, ir_reg[7:0]}
  ) else $error("banked operand address wrong");

  lit_offset_a: assert property (
    state_reg == ST_EXEC && dec.op == OP_XOR && !ir_reg[8]
    && ext_reg && ir_reg[7:0] <= LIT_OFS_MAX
    |-> mem_raddr == ptr_reg[2] + {4'h0, ir_reg[7:0]}
  ) else $error("indexed literal offset address wrong");

  xor_one_cycle_a: assert property (
    issue && state_reg == ST_IDLE && dec.op == OP_XOR
    |=> state_reg == ST_EXEC [*4] ##1 state_reg == ST_IDLE
  ) else $error("xor did not take one instruction cycle");

  flags_hold_a: assert property (
    !(fire && dec.op == OP_XOR)
    |=> $stable(neg_reg) && $stable(zero_reg)
  ) else $error("flags changed outside xor");

  ext_gate_a: assert property (
    issue && state_reg == ST_IDLE && !ext_reg
    && pwdata[15:12] == 4'hE
    |=> ill_reg && state_reg == ST_IDLE
  ) else $error("extension ran while disabled");

  ptr_add_a: assert property (
    fire && dec.op == OP_ADDP
    |=> ptr_reg[sel] == $past(ptr_reg[sel]) + $past(lit6)
  ) else $error("pointer add result wrong");

  frame_ret_a: assert property (
    fire && (dec.op == OP_ADDRET || dec.op == OP_SUBRET)
    |=> pc_reg == $past(tos_reg) ##0 state_reg == ST_EXEC [*4]
        ##1 state_reg == ST_IDLE
  ) else $error("frame return wrong pc or length");

  call_acc_a: assert property (
    fire && dec.op == OP_CALL_VIA_ACCUMULATOR
    |=> pc_reg[7:0] == $past(acc_reg) && tos_reg == $past(pc_reg)
  ) else $error("call target not from accumulator");

  push_lit_a: assert property (
    fire && dec.op == OP_PUSH_LITERAL
    |-> mem_wr.en && mem_wr.addr == ptr_reg[2]
        && mem_wr.data == ir_reg[7:0]
        ##1 ptr_reg[2] == $past(ptr_reg[2]) - 12'h001
  ) else $error("push literal wrong");

  move_frame_a: assert property (
    fire && dec.op == OP_MOVE_FRAME_TO_FILE
    |-> mem_raddr == ptr_reg[2] + {5'h0, ir_reg[6:0]}
        && mem_wr.en && mem_wr.addr == w2_reg[11:0]
  ) else $error("frame to file move addressed wrong");

endmodule : xsd_core

// file: tb/xsd_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module xor_and_stack_instruction_decode_bench;
  import xsd_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [31:0] rx;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          w1;
  int          w2;

  always #25 pclk = ~pclk;

  xsd_core xsd_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ------------------------------------------------------------
  // apb master
  // ------------------------------------------------------------
  // psel stays up between calls: every transfer is back to back
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output int st);
    st = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      st++;
      @(posedge pclk);
    end
    r = prdata;
    err = pslverr;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    int st;
    xfer(1'b1, a, d, r, st);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
    input string nm);
    logic [31:0] r;
    int st;
    xfer(1'b0, a, 32'h0, r, st);
    `CHK(nm, e, r)
  endtask : rd_chk

  task automatic mem_set(input logic [11:0] a, input logic [7:0] d);
    wr(OFS_MADDR, {20'h0, a});
    wr(OFS_MDATA, {24'h0, d});
  endtask : mem_set

  task automatic mem_chk(input logic [11:0] a, input logic [7:0] e,
    input string nm);
    wr(OFS_MADDR, {20'h0, a});
    rd_chk(OFS_MDATA, {24'h0, e}, nm);
  endtask : mem_chk

  // the write after the issue stalls until the instruction is done
  task automatic run(input logic [15:0] ins, output int st);
    logic [31:0] r;
    wr(OFS_INSTR, {16'h0, ins});
    xfer(1'b1, OFS_MADDR, 32'h0, r, st);
  endtask : run

  task automatic final_report;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(OFS_CTRL, 32'h1, "ctrl reset");
    rd_chk(OFS_STATUS, 32'h0, "status reset");
    mem_set(12'hF60, 8'hAF);
    wr(OFS_ACC, 32'hB5);
    run(16'h1860, w1);
    rd_chk(OFS_ACC, 32'h1A, "xor to acc");
    run(16'h1A60, w1);
    mem_chk(12'hF60, 8'hB5, "xor to file");
    rd_chk(OFS_STATUS, 32'h4, "xor negative");
    rd_chk(OFS_ACC, 32'h1A, "acc kept");
    mem_set(12'h210, 8'h1A);
    wr(OFS_BANK, 32'h2);
    run(16'h1910, w1);
    rd_chk(OFS_ACC, 32'h0, "xor banked");
    rd_chk(OFS_STATUS, 32'h8, "xor zero");
    wr(OFS_PTR2, 32'h300);
    mem_set(12'h305, 8'h33);
    mem_set(12'h005, 8'h11);
    run(16'h1805, w1);
    rd_chk(OFS_ACC, 32'h33, "xor indexed");
    wr(OFS_CTRL, 32'h0);
    run(16'h1805, w1);
    rd_chk(OFS_ACC, 32'h22, "xor ext off");
    run(16'hE841, w1);
    rd_chk(OFS_STATUS, 32'h10, "ext op off");
    rd_chk(OFS_PTR1, 32'h0, "ptr1 kept");
    wr(OFS_STATUS, 32'h10);
    wr(OFS_CTRL, 32'h1);
    run(16'hEC00, w1);
    rd_chk(OFS_STATUS, 32'h10, "unknown op");
    wr(OFS_STATUS, 32'h10);
    // zero flag set, must survive every extension op below
    wr(OFS_ACC, 32'h33);
    run(16'h1805, w1);
    wr(OFS_PTR1, 32'hFF0);
    run(16'hE87F, w2);
    rd_chk(OFS_PTR1, 32'h02F, "add ptr1");
    `CHK("add stall", w1, w2)
    run(16'hE901, w2);
    rd_chk(OFS_PTR0, 32'hFFF, "sub ptr0");
    rd_chk(OFS_STATUS, 32'h8, "flags kept");
    wr(OFS_PTR2, 32'h3FF);
    wr(OFS_TOS, 32'h1234);
    run(16'hE8E3, w2);
    rd_chk(OFS_PTR2, 32'h422, "frame add");
    rd_chk(OFS_PC, 32'h1234, "add ret pc");
    `CHK("add ret stall", w1 + 4, w2)
    wr(OFS_PC, 32'h0);
    run(16'hE9C1, w2);
    rd_chk(OFS_PTR2, 32'h421, "frame sub");
    rd_chk(OFS_PC, 32'h1234, "sub ret pc");
    `CHK("sub ret stall", w1 + 4, w2)
    wr(OFS_ACC, 32'h56);
    run(16'h0014, w2);
    rd_chk(OFS_TOS, 32'h1234, "call tos");
    rd_chk(OFS_PC, 32'h1256, "call pc");
    `CHK("call stall", w1 + 4, w2)
    run(16'hEA77, w2);
    mem_chk(12'h421, 8'h77, "push data");
    rd_chk(OFS_PTR2, 32'h420, "push ptr");
    `CHK("push stall", w1, w2)
    rd_chk(OFS_STATUS, 32'h8, "flags kept");
    wr(OFS_INSTR, 32'hEB01);
    rd_chk(OFS_STATUS, 32'hA, "first word");
    run(16'hF123, w2);
    mem_chk(12'h123, 8'h77, "move to file");
    `CHK("move stall", w1 + 4, w2)
    wr(OFS_INSTR, 32'hEB81);
    run(16'hF002, w2);
    mem_chk(12'h422, 8'h77, "move frame");
    `CHK("move2 stall", w1 + 4, w2)
    wr(OFS_INSTR, 32'hEB01);
    run(16'h1234, w2);
    rd_chk(OFS_STATUS, 32'h18, "bad word2");
    xfer(1'b0, 8'h30, 32'h0, rx, w2);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rx)
    final_report();
  end

  initial begin
    #(50 * 20000);
    n_mismatch++;
    final_report();
  end
endmodule : xor_and_stack_instruction_decode_bench
